// [hdl/ccm_pkg.sv]
// Constants, types and states shared by the core memory array control
package ccm_pkg;

    // ********************************************************
    // Array geometry
    // ********************************************************
    // Largest module population
    localparam int MOD_MAX = 8;
    // Width of a module number
    localparam int MOD_W = 3;
    // Planes per module: thirteen data, one parity
    localparam int PLANES = 14;
    // Data planes per syllable
    localparam int DATA_BITS = 13;
    // Plane index holding parity
    localparam int PAR_PLANE = 13;
    // Cores along the X and Y dimensions of a plane
    localparam int X_LINES = 128;
    localparam int Y_LINES = 64;
    // X and Y line index widths
    localparam int X_W = 7;
    localparam int Y_W = 6;
    // Sectors per syllable and locations per sector
    localparam int SECTORS = 16;
    localparam int SECT_LOCS = 256;
    // In-module address: four sector bits and eight location bits
    localparam int LOC_W = 12;
    // Core index per module: syllable bit above the address
    localparam int CORE_W = 13;
    localparam int CORE_ENTRIES = 8192;
    // Operand address width and its residual select bit
    localparam int OPA_W = 9;
    localparam int RESID_BIT = 8;
    // Sector number used as residual memory
    localparam logic [3:0] RESID_SECTOR = 4'hF;
    // Computer word width and bit counter width
    localparam int WORD_BITS = 26;
    localparam int CNT_W = 5;
    localparam logic [4:0] LAST_BIT = 5'h19;

    // ********************************************************
    // Types
    // ********************************************************
    // Access request taken with the sync impulse
    typedef struct packed {
        logic fetch;
        logic wr;
        logic [3:0] sector;
        logic [8:0] addr;
        logic [25:0] wdata;
    } ccm_req_s;

    // Program-controlled module choice
    typedef struct packed {
        logic [2:0] instr_mod;
        logic [2:0] data_mod;
    } ccm_modsel_s;

    // Access sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_RD0 = 7'h02,
        ST_ST0 = 7'h04,
        ST_RD1 = 7'h08,
        ST_ST1 = 7'h10,
        ST_SHIFT = 7'h20,
        ST_DONE = 7'h40
    } ccm_state_e;

endpackage

// [hdl/ccm_core_ctrl.sv]
// Core memory array control: access sequencing, parity, serial word out
// ************************************************************
// Summary of operation
// - One to eight independent modules supported
// - Fourteen planes of 128 by 64 cores
// - 4096 locations of 28 bits, no redundancy
// - Simplex single modules; duplex pairs mirror contents
// - 128-core dimension split into syllable halves
// - Sixteen sectors of 64 by 4 cores per syllable half
// - Last sector is shared residual memory
// - Thirteen data planes plus one parity plane
// - Ordinary sector locations octal 0 to 377
// - Residual sector addressed octal 400 to 777
// - Separate instruction and data module selection
// - Two syllables sent serially as one word
// - Odd parity stored per 13-bit half
// - Every read checked against stored parity
// - Read clears cores, latches sensed ones
// - Latch holds bit until restored and passed
// - Store drives ones, inhibits zero planes
// - Inhibit only during store cycles
// - Exactly one X and one Y line
// - One X/Y pair selects all planes
// - Per-plane sense path and buffer latch
// ************************************************************
`timescale 1ns/1ps
`default_nettype none

module ccm_core_ctrl #(
    // Populated modules, one to eight
    parameter int NUM_MODULES = ccm_pkg::MOD_MAX
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic dup_mode,
    input wire logic mod_load,
    input wire ccm_pkg::ccm_modsel_s mod_cfg,
    input wire logic sync,
    input wire ccm_pkg::ccm_req_s req,
    output logic busy,
    output logic done,
    output logic sel_err,
    output logic par_err,
    output logic ser_bit,
    output logic ser_valid,
    output logic drive_rd,
    output logic drive_st,
    output logic [ccm_pkg::X_LINES-1:0] x_sel,
    output logic [ccm_pkg::Y_LINES-1:0] y_sel,
    output logic [ccm_pkg::PLANES-1:0] inhibit
);
    import ccm_pkg::*;

    // ********************************************************
    // Registers
    // ********************************************************
    // Sequencer state
    ccm_state_e state_q;
    ccm_state_e state_d;
    // Request held for the whole access
    ccm_req_s req_q;
    ccm_req_s req_d;
    // Module chosen for this access and duplex flag
    logic [MOD_W-1:0] mod_q;
    logic [MOD_W-1:0] mod_d;
    logic dup_q;
    logic dup_d;
    // Program-controlled module numbers
    ccm_modsel_s msel_q;
    // Per-plane buffer latches
    logic [PLANES-1:0] latch_q;
    logic [PLANES-1:0] latch_d;
    // Assembled computer word and its bit counter
    logic [WORD_BITS-1:0] word_q;
    logic [WORD_BITS-1:0] word_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    // Registered outputs
    logic busy_q;
    logic done_q;
    logic sel_err_q;
    logic par_err_q;
    logic ser_bit_q;
    logic ser_valid_q;
    logic drive_rd_q;
    logic drive_st_q;
    logic [X_LINES-1:0] x_sel_q;
    logic [Y_LINES-1:0] y_sel_q;
    logic [PLANES-1:0] inhibit_q;

    // ********************************************************
    // Address formation
    // ********************************************************
    // In-module address from sector and operand address
    function automatic logic [LOC_W-1:0] loc_of(input ccm_req_s r);
        logic [3:0] sect;
        sect = r.sector;
        // upper half of operand space is residual
        if (r.addr[RESID_BIT]) begin
            // shared residual sector of the module
            sect = RESID_SECTOR;
        end
        // low eight bits pick one of 256
        return {sect, r.addr[7:0]};
    endfunction

    // Syllable being worked on now and next
    wire syl_q = (state_q == ST_RD1) || (state_q == ST_ST1);
    wire syl_d = (state_d == ST_RD1) || (state_d == ST_ST1);
    // Location for the array access in progress
    wire [LOC_W-1:0] loc_q = loc_of(req_q);
    // Location for the lines driven next cycle
    wire [LOC_W-1:0] loc_d = loc_of(req_d);
    // syllable picks the half of the 128-core dimension
    wire [X_W-1:0] x_idx_d = {syl_d, loc_d[5:0]};
    // remaining address bits walk the Y dimension
    wire [Y_W-1:0] y_idx_d = loc_d[11:6];
    // Core index inside a module
    wire [CORE_W-1:0] cidx = {syl_q, loc_q};
    // Array cycle kinds in progress
    wire core_rd = (state_q == ST_RD0) || (state_q == ST_RD1);
    wire core_st = (state_q == ST_ST0) || (state_q == ST_ST1);
    wire rd_next = (state_d == ST_RD0) || (state_d == ST_RD1);
    wire st_next = (state_d == ST_ST0) || (state_d == ST_ST1);

    // ********************************************************
    // Core arrays
    // ********************************************************
    // Sense outputs of each module at the addressed location
    logic [PLANES-1:0] sense_mod [NUM_MODULES];
    // Duplex partner of the selected module
    wire [MOD_W-1:0] partner = {mod_q[2:1], 1'b1};
    // Data rewritten by the store cycle
    logic [PLANES-1:0] store_word;

    // one generate copy per populated module
    for (genvar m = 0; m < NUM_MODULES; m++) begin : g_mod
        // one bit per core, no redundancy
        logic [PLANES-1:0] mem_q [CORE_ENTRIES];
        // duplex cycles both modules of the pair
        wire hit = (mod_q == MOD_W'(m)) ||
                   (dup_q && (partner == MOD_W'(m)));
        // one index reaches the same core in every plane
        assign sense_mod[m] = mem_q[cidx];
        // Array write: clear on read, restore on store
        always_ff @(posedge clk) begin
            if (hit && core_rd) begin
                // read drives the location to zero
                mem_q[cidx] <= '0;
            end else if (hit && core_st) begin
                // ones switched, inhibited planes stay zero
                mem_q[cidx] <= store_word;
            end
        end
    end

    // Duplex reads from the even module only; error-driven
    // buffer selection between the pair is not built here.
    wire [PLANES-1:0] sense = sense_mod[mod_q];
    // stored parity is odd, even count means error
    wire sense_bad = ~(^sense);
    // New syllable data on write, latched data otherwise
    wire [DATA_BITS-1:0] new_syl = syl_q ? req_q.wdata[25:13] :
                                           req_q.wdata[12:0];
    wire [DATA_BITS-1:0] keep_syl = latch_q[DATA_BITS-1:0];
    wire [DATA_BITS-1:0] st_data = req_q.wr ? new_syl : keep_syl;
    // parity sits in the fourteenth plane
    assign store_word = {~(^st_data), st_data};
    // Same store word as seen one cycle ahead for the inhibit
    wire [DATA_BITS-1:0] nsyl_d = syl_d ? req_q.wdata[25:13] :
                                          req_q.wdata[12:0];
    wire [DATA_BITS-1:0] ldat_d = latch_d[DATA_BITS-1:0];
    wire [DATA_BITS-1:0] sdat_d = req_q.wr ? nsyl_d : ldat_d;
    wire [PLANES-1:0] sword_d = {~(^sdat_d), sdat_d};

    // ********************************************************
    // Request decode
    // ********************************************************
    // fetch and operand each use their own module
    wire [MOD_W-1:0] req_mod = req.fetch ? msel_q.instr_mod :
                                           msel_q.data_mod;
    // duplex addresses the pair by its even member
    wire [MOD_W-1:0] pick_mod = dup_mode ? {req_mod[2:1], 1'b0} :
                                           req_mod;
    // Module outside the population is refused
    wire mod_ok = (32'(pick_mod) < NUM_MODULES);
    // access begins on the sync impulse when idle
    wire start = (state_q == ST_IDLE) && sync;
    wire take = start && mod_ok;
    wire refuse = start && !mod_ok;

    // ********************************************************
    // Sequencer next state
    // ********************************************************
    // read cycle followed at once by a store cycle
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_RD0;
                end
            end
            ST_RD0: begin
                state_d = ST_ST0;
            end
            ST_ST0: begin
                state_d = ST_RD1;
            end
            ST_RD1: begin
                state_d = ST_ST1;
            end
            ST_ST1: begin
                state_d = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (cnt_q == LAST_BIT) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ********************************************************
    // Data path next values
    // ********************************************************
    // Request and module captured at start only
    assign req_d = take ? req : req_q;
    assign mod_d = take ? pick_mod : mod_q;
    assign dup_d = take ? dup_mode : dup_q;
    // each plane's sense bit sets its own latch
    // latch holds until the next read overwrites it
    assign latch_d = core_rd ? sense : latch_q;

    // Word assembly: syllable 0 low, syllable 1 high
    always_comb begin
        word_d = word_q;
        if (state_q == ST_RD0) begin
            word_d[12:0] = sense[DATA_BITS-1:0];
        end else if (state_q == ST_RD1) begin
            word_d[25:13] = sense[DATA_BITS-1:0];
        end
    end

    // Serial bit counter runs only while shifting
    assign cnt_d = (state_q == ST_SHIFT) ? cnt_q + 5'h01 : 5'h00;

    // ********************************************************
    // Sequencer and data registers
    // ********************************************************
    // State, request and latch registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            mod_q <= '0;
            dup_q <= 1'b0;
            latch_q <= '0;
            word_q <= '0;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            mod_q <= mod_d;
            dup_q <= dup_d;
            latch_q <= latch_d;
            word_q <= word_d;
            cnt_q <= cnt_d;
        end
    end

    // Module selection loads any time; a running access
    // keeps the module it started with.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            msel_q <= '0;
        end else if (mod_load) begin
            // program sets instruction and data modules
            msel_q <= mod_cfg;
        end
    end

    // ********************************************************
    // Array drive outputs
    // ********************************************************
    // Drive lines and inhibits follow the next state
    always_ff @(posedge clk) begin
        if (!nrst) begin
            drive_rd_q <= 1'b0;
            drive_st_q <= 1'b0;
            x_sel_q <= '0;
            y_sel_q <= '0;
            inhibit_q <= '0;
        end else begin
            drive_rd_q <= rd_next;
            drive_st_q <= st_next;
            // one X and one Y line, only while cycling
            x_sel_q <= (rd_next || st_next) ?
                       (X_LINES'(1) << x_idx_d) : '0;
            y_sel_q <= (rd_next || st_next) ?
                       (Y_LINES'(1) << y_idx_d) : '0;
            inhibit_q <= st_next ? ~sword_d : '0;
        end
    end

    // ********************************************************
    // Computer side outputs
    // ********************************************************
    // Status, error and serial word registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sel_err_q <= 1'b0;
            par_err_q <= 1'b0;
            ser_bit_q <= 1'b0;
            ser_valid_q <= 1'b0;
        end else begin
            busy_q <= (state_d != ST_IDLE);
            done_q <= (state_q == ST_SHIFT) && (cnt_q == LAST_BIT);
            // Refused sync gets a one-cycle error, no cycle
            sel_err_q <= refuse;
            // pulse per syllable whose parity fails
            par_err_q <= core_rd && sense_bad;
            // low bit first, syllable 0 then syllable 1
            ser_bit_q <= (state_q == ST_SHIFT) ? word_q[cnt_q] : 1'b0;
            ser_valid_q <= (state_q == ST_SHIFT);
        end
    end

    // Ports straight from flip-flops
    assign busy = busy_q;
    assign done = done_q;
    assign sel_err = sel_err_q;
    assign par_err = par_err_q;
    assign ser_bit = ser_bit_q;
    assign ser_valid = ser_valid_q;
    assign drive_rd = drive_rd_q;
    assign drive_st = drive_st_q;
    assign x_sel = x_sel_q;
    assign y_sel = y_sel_q;
    assign inhibit = inhibit_q;

endmodule

`default_nettype wire

// [verification/ccm_core_ctrl_props.sv]
// Port-level checks for the core memory array control
`timescale 1ns/1ps
`default_nettype none
module ccm_core_ctrl_props #(
    parameter int NUM_MODULES = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sync,
    input wire logic busy,
    input wire logic done,
    input wire logic sel_err,
    input wire logic par_err,
    input wire logic ser_valid,
    input wire logic drive_rd,
    input wire logic drive_st,
    input wire logic [ccm_pkg::X_LINES-1:0] x_sel,
    input wire logic [ccm_pkg::Y_LINES-1:0] y_sel,
    input wire logic [ccm_pkg::PLANES-1:0] inhibit
);
    import ccm_pkg::*;
    // Length of the current serial window
    logic [4:0] vcnt_q;
    // Counter restarts whenever the window closes
    always_ff @(posedge clk) begin
        vcnt_q <= (!nrst || !ser_valid) ? 5'h0 : vcnt_q + 5'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    rd_first_a: assert property (
        $rose(busy) |-> drive_rd && x_sel[63:0] != 64'h0)
        else $error("access did not open with a syllable 0 read");
    cycle_order_a: assert property (
        $rose(busy) |-> drive_rd ##1 (drive_st && !drive_rd) ##1 drive_rd
        ##1 drive_st ##1 (!drive_rd && !drive_st))
        else $error("read and store cycles out of order");
    syl_one_a: assert property (
        drive_rd && $past(drive_st) |-> x_sel[127:64] != 64'h0)
        else $error("second read not in syllable 1 half");
    same_loc_a: assert property (
        drive_st |-> $past(drive_rd) && x_sel == $past(x_sel)
        && y_sel == $past(y_sel))
        else $error("store cycle moved off the read location");
    one_line_a: assert property (
        drive_rd || drive_st |-> $onehot(x_sel) && $onehot(y_sel))
        else $error("not exactly one X and one Y line");
    lines_off_a: assert property (
        !(drive_rd || drive_st) |-> x_sel == '0 && y_sel == '0)
        else $error("drive line energized outside a cycle");
    inh_store_a: assert property (
        inhibit != '0 |-> drive_st)
        else $error("inhibit outside a store cycle");
    ser_len_a: assert property (
        !ser_valid && vcnt_q != 5'h0 |-> vcnt_q == 5'h1A)
        else $error("serial word not 26 bits long");
    done_end_a: assert property (
        $fell(ser_valid) |-> $past(done) && !busy)
        else $error("access did not end after the word");
    sync_take_a: assert property (
        sync && !busy |=> busy != sel_err)
        else $error("sync neither taken nor refused");
    par_rd_a: assert property (
        par_err |-> $past(drive_rd))
        else $error("parity flag without a read");
endmodule
`default_nettype wire

// [verification/ccm_cpu_model.sv]
// Computer-side model: sync impulse, request and serial word capture
`timescale 1ns/1ps
`default_nettype none
module ccm_cpu_model (
    input wire logic clk,
    input wire logic done,
    input wire logic sel_err,
    input wire logic par_err,
    input wire logic ser_bit,
    input wire logic ser_valid,
    output logic sync,
    output ccm_pkg::ccm_req_s req
);
    import ccm_pkg::*;
    // Quiet request lines until the first access
    initial begin
        sync = 1'b0;
        req = '0;
    end
    task automatic access(input ccm_req_s r, output logic [25:0] rd,
        output logic perr, output logic serr, output logic ok);
        int n;
        int i;
        rd = '0;
        i = 0;
        ok = 1'b0;
        perr = 1'b0;
        serr = 1'b0;
        @(negedge clk);
        sync = 1'b1;
        req = r;
        @(negedge clk);
        sync = 1'b0;
        // Stale request inverted, so nothing can lean on it
        req = ~r;
        // Bounded wait: the module times itself, we only listen
        for (n = 0; n < 40 && !ok; n++) begin
            if (ser_valid === 1'b1 && i < 26) begin
                rd[i] = ser_bit;
                i++;
            end
            if (par_err !== 1'b0) perr = 1'b1;
            if (sel_err === 1'b1) serr = 1'b1;
            if (sel_err === 1'b1 || done === 1'b1) ok = 1'b1;
            if (!ok) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the core memory array control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ccm_pkg::*;
    logic clk, nrst, dup_mode, mod_load, sync;
    ccm_modsel_s mod_cfg;
    ccm_req_s req;
    logic busy, done, sel_err, par_err, ser_bit, ser_valid;
    logic drive_rd, drive_st;
    logic [X_LINES-1:0] x_sel;
    logic [Y_LINES-1:0] y_sel;
    logic [PLANES-1:0] inhibit;
    int err_count, num_checks, seed, cur_i, cur_d;
    logic [31:0] ra, rb;
    // Core contents model, keyed by module, syllable, location
    logic [13:0] mem [int];
    logic [X_LINES-1:0] xq [$];
    logic [Y_LINES-1:0] yq [$];
    logic [PLANES-1:0] iq [$];
    ccm_core_ctrl #(.NUM_MODULES(6)) u_dut (.clk(clk), .nrst(nrst),
        .dup_mode(dup_mode), .mod_load(mod_load), .mod_cfg(mod_cfg),
        .sync(sync), .req(req), .busy(busy), .done(done),
        .sel_err(sel_err), .par_err(par_err), .ser_bit(ser_bit),
        .ser_valid(ser_valid), .drive_rd(drive_rd), .drive_st(drive_st),
        .x_sel(x_sel), .y_sel(y_sel), .inhibit(inhibit));
    ccm_cpu_model u_cpu (.clk(clk), .done(done), .sel_err(sel_err),
        .par_err(par_err), .ser_bit(ser_bit), .ser_valid(ser_valid),
        .sync(sync), .req(req));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Record lines of each drive cycle, inhibit of each store cycle
    always @(negedge clk) begin
        if (drive_rd === 1'b1 || drive_st === 1'b1) begin
            xq.push_back(x_sel);
            yq.push_back(y_sel);
        end
        if (drive_st === 1'b1) iq.push_back(inhibit);
    end
    task automatic check(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic set_mods(input int i, input int d);
        @(negedge clk);
        mod_load = 1'b1;
        mod_cfg = '{i[2:0], d[2:0]};
        cur_i = i;
        cur_d = d;
        @(negedge clk);
        mod_load = 1'b0;
    endtask
    // One access, compared with the model at every result
    task automatic acc(input logic f, input logic w, input logic [3:0] s,
        input logic [8:0] a, input logic [25:0] wd);
        logic [25:0] rd;
        logic pe, se, ok, known;
        logic [11:0] loc;
        logic [13:0] old, nw;
        int m, k;
        m = f ? cur_i : cur_d;
        if (dup_mode) m = m & 6;
        loc = a[8] ? {4'hF, a[7:0]} : {s, a[7:0]};
        known = 1'b1;
        xq.delete();
        yq.delete();
        iq.delete();
        u_cpu.access('{f, w, s, a, wd}, rd, pe, se, ok);
        check(ok, "access hung");
        if (!ok) tally_and_finish();
        check(se === (m > 5), "module refusal");
        check(xq.size() == (m > 5 ? 0 : 4), "drive cycles");
        if (m > 5) return;
        for (int y = 0; y < 2; y++) begin
            k = m * 8192 + y * 4096 + int'(loc);
            old = mem.exists(k) ? mem[k] : 'x;
            known &= mem.exists(k);
            if (known) check(rd[13*y +: 13] === old[12:0], "data");
            nw = w ? {~^wd[13*y +: 13], wd[13*y +: 13]} : old;
            if (w || known) check(iq[y] === ~nw, "inhibit");
            check(xq[2*y] === (128'h1 << {y[0], loc[5:0]}) &&
                yq[2*y] === (64'h1 << loc[11:6]), "array lines");
            if (w) mem[k] = nw;
            if (w && dup_mode) mem[k + 8192] = nw;
        end
        if (known) check(pe === 1'b0, "parity flag");
    endtask
    initial begin
        seed = 50481;
        nrst = 1'b0;
        dup_mode = 1'b0;
        mod_load = 1'b0;
        mod_cfg = '0;
        cur_i = 0;
        cur_d = 0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        for (int t = 0; t < 12; t++) begin
            ra = $random(seed);
            rb = $random(seed);
            set_mods(int'(ra[16:14]) % 6, int'(ra[19:17]) % 6);
            acc(ra[13], 1'b1, ra[12:9], ra[8:0], rb[25:0]);
            acc(ra[13], 1'b0, ra[12:9], ra[8:0], ~rb[25:0]);
            acc(ra[13], 1'b0, ra[12:9], ra[8:0], rb[25:0]);
            acc(~ra[13], 1'b0, ra[12:9], ra[8:0], rb[25:0]);
            repeat (ra[21:20]) @(negedge clk);
        end
        $display("Test random traffic done");
        acc(1'b0, 1'b1, 4'h3, 9'h1FF, 26'h2AAAAAA);
        acc(1'b0, 1'b0, 4'hF, 9'h0FF, 26'h0);
        acc(1'b0, 1'b1, 4'h0, 9'h100, 26'h1555555);
        acc(1'b0, 1'b0, 4'h9, 9'h100, 26'h0);
        $display("Test residual sector done");
        set_mods(0, 3);
        dup_mode = 1'b1;
        acc(1'b0, 1'b1, 4'h5, 9'h042, 26'h3FFFFFF);
        dup_mode = 1'b0;
        acc(1'b0, 1'b0, 4'h5, 9'h042, 26'h0);
        $display("Test duplex pair done");
        set_mods(7, 6);
        acc(1'b1, 1'b0, 4'h0, 9'h000, 26'h0);
        acc(1'b0, 1'b0, 4'h0, 9'h000, 26'h0);
        $display("Test module refusal done");
        tally_and_finish();
    end
endmodule
bind ccm_core_ctrl ccm_core_ctrl_props #(.NUM_MODULES(NUM_MODULES)) u_props (
    .clk(clk), .nrst(nrst), .sync(sync), .busy(busy), .done(done),
    .sel_err(sel_err), .par_err(par_err), .ser_valid(ser_valid),
    .drive_rd(drive_rd), .drive_st(drive_st), .x_sel(x_sel),
    .y_sel(y_sel), .inhibit(inhibit));
`default_nettype wire
